// ---- design/gtw_port.v ----
// Operation
// R1: any bus clock up to 400kHz works, no speed setting needed.
// R2: address byte is 011, four identity bits, then direction bit.
// R3: location 7Dh holds identity bits in upper nibble, default 0110.
// R4: master may probe presence with start, address and direction only.
// R5: every byte is acknowledged before the next byte proceeds; here a data byte that meets a full write buffer gets no ack.
// R6: write sends address with direction 0, pointer byte, then data bytes.
// R7: each data byte stored at pointer; pointer increments after last bit.
// R8: master ends a write with stop or repeated start.
// R9: write data discarded once auto-increment passes location 4Fh.
// R10: writes to read-only, reserved, or auto-incremented FEh are discarded.
// R11: partial or unacknowledged bytes are never committed.
// R12: serial writes touch only the shadow copy, not nonvolatile storage.
// R13: read is pointer write, repeated start, address with direction 1.
// R14: read returns pointer byte MSB first, then pointer increments.
// R15: reads past location FFh return FFh.
// R16: reserved locations may read as anything.
// R17: master acks bytes to continue, nacks the last, then device releases.
// R18: acknowledge address only when all seven bits match own identity.
// R19: multi-byte values are MSB first at the even address.
// R20: ack holds data low through ninth pulse; nack leaves it high.
// R21: data line driven only low, open drain, external pull-up.
// R22: on address mismatch stay released and ignore until next start.
// R23: pointer byte replaces pointer; kept across repeated start.
`timescale 1ns/1ps
`include "gtw_map.vh"
module gtw_port (
  input wire core_clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  output reg [7:0] mem_rd_addr,
  input wire [7:0] mem_rd_data,
  output wire wr_valid,
  input wire wr_ready,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  output wire [3:0] bus_identity_low_bits
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACK_A = 7'h04;
  localparam [6:0] ST_WR = 7'h08;
  localparam [6:0] ST_ACK_W = 7'h10;
  localparam [6:0] ST_RD = 7'h20;
  localparam [6:0] ST_ACK_M = 7'h40;

  reg scl_s1;
  reg scl_s2;
  reg scl_d;
  reg sda_s1;
  reg sda_s2;
  reg sda_d;
  reg [6:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] tx;
  reg rw;
  reg ptr_phase;
  reg first_data;
  reg [8:0] ptr;
  reg [7:0] bus_identity_config;
  reg push;
  reg [15:0] push_word;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [7:0] rd_byte;
  wire addr_match;
  wire wr_allowed;
  wire fifo_in_ready;

  // a third stage behind the two-flop synchronisers gives edges and start/stop
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

  assign sda_out = 1'b0; // [R21]
  assign bus_identity_low_bits = bus_identity_config[`GTW_CFG_ID_MSB:`GTW_CFG_ID_LSB];
  assign addr_match = (shreg[7:1] == {`GTW_ID_FIXED, bus_identity_low_bits}); // [R2] [R18]
  // reserved nibble of the identity location reads zero
  assign rd_byte = ptr[8] ? `GTW_PAST_TOP_DATA : // [R15]
    (ptr[7:0] == `GTW_CFG_ADDR) ? {bus_identity_low_bits, 4'h0} : mem_rd_data; // [R3] [R16]
  // beyond 4Fh only a byte aimed straight at a location by the pointer byte lands
  assign wr_allowed = ~ptr[8] & ((ptr[7:0] <= `GTW_LAST_AUTO_WR) | first_data); // [R9] [R10]

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'hff;
      rw <= 1'b0;
      ptr_phase <= 1'b0;
      first_data <= 1'b0;
      ptr <= `GTW_PTR_RESET;
      bus_identity_config <= `GTW_CFG_RESET; // [R3]
      sda_oe <= 1'b0;
      push <= 1'b0;
      push_word <= 16'h0000;
      mem_rd_addr <= 8'h00;
    end
    else
    begin
      push <= 1'b0;
      mem_rd_addr <= ptr[7:0];
      // sampling at the core clock holds for any scl up to 400kHz
      if (start_cond) // [R1] [R13]
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE;
        sda_oe <= 1'b0; // [R17]
      end
      else
      begin
        case (state)
          ST_ADDR:
          begin
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `GTW_BITS_PER_BYTE)
            begin
              if (addr_match) // [R4] [R18]
              begin
                sda_oe <= 1'b1; // [R20]
                rw <= shreg[0];
                state <= ST_ACK_A;
              end
              else
              begin
                state <= ST_IDLE; // [R22]
              end
            end
          end
          ST_ACK_A:
          begin
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (rw)
              begin
                tx <= rd_byte; // [R13] [R14]
                sda_oe <= ~rd_byte[7];
                state <= ST_RD;
              end
              else
              begin
                sda_oe <= 1'b0; // [R6]
                ptr_phase <= 1'b1;
                state <= ST_WR;
              end
            end
          end
          ST_WR:
          begin
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `GTW_BITS_PER_BYTE)
            begin
              if (ptr_phase)
              begin
                ptr <= {1'b0, shreg}; // [R23]
                ptr_phase <= 1'b0;
                first_data <= 1'b1;
                sda_oe <= 1'b1; // [R5]
                state <= ST_ACK_W;
              end
              else if (!fifo_in_ready)
              begin
                // full buffer: withhold the ack and drop the byte
                state <= ST_IDLE; // [R11] [R20]
              end
              else
              begin
                if (wr_allowed && ptr[7:0] == `GTW_CFG_ADDR)
                begin
                  bus_identity_config <= {shreg[7:4], 4'h0}; // [R3]
                end
                else if (wr_allowed && ptr[7:0] != `GTW_FUNCTION_COMMAND_BYTE_ADDR)
                begin
                  push <= 1'b1; // [R7] [R12]
                  push_word <= {ptr[7:0], shreg};
                end
                else if (wr_allowed)
                begin
                  push <= 1'b1; // [R10]
                  push_word <= {ptr[7:0], shreg};
                end
                if (!ptr[8])
                begin
                  ptr <= ptr + 9'h001; // [R7] [R19]
                end
                first_data <= 1'b0;
                sda_oe <= 1'b1; // [R5] [R20]
                state <= ST_ACK_W;
              end
            end
          end
          ST_ACK_W:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0; // [R8]
              bit_cnt <= 4'h0;
              state <= ST_WR;
            end
          end
          ST_RD:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == `GTW_LAST_TX_BIT)
              begin
                sda_oe <= 1'b0;
                if (!ptr[8])
                begin
                  ptr <= ptr + 9'h001; // [R14] [R15]
                end
                state <= ST_ACK_M;
              end
              else
              begin
                tx <= {tx[6:0], 1'b1};
                sda_oe <= ~tx[6]; // [R21]
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_ACK_M:
          begin
            if (scl_rise && sda_s2)
            begin
              state <= ST_IDLE; // [R17]
            end
            else if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              tx <= rd_byte; // [R14] [R5]
              sda_oe <= ~rd_byte[7];
              state <= ST_RD;
            end
          end
          default:
          begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  gtw_fifo #(
    .WIDTH(`GTW_FIFO_WIDTH),
    .DEPTH(`GTW_FIFO_DEPTH),
    .AW(`GTW_FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );
endmodule // gtw_port

// ---- design/gtw_map.vh ----
`ifndef GTW_MAP_VH
`define GTW_MAP_VH
`define GTW_ID_FIXED 3'h3
`define GTW_CFG_ADDR 8'h7d
`define GTW_CFG_ID_MSB 7
`define GTW_CFG_ID_LSB 4
`define GTW_CFG_RESET 8'h60
`define GTW_LAST_AUTO_WR 8'h4f
`define GTW_FUNCTION_COMMAND_BYTE_ADDR 8'hfe
`define GTW_PAST_TOP_DATA 8'hff
`define GTW_PTR_RESET 9'h000
`define GTW_FIFO_WIDTH 16
`define GTW_FIFO_DEPTH 32
`define GTW_FIFO_AW 5
`define GTW_BITS_PER_BYTE 4'h8
`define GTW_LAST_TX_BIT 4'h7
`endif

// ---- design/gtw_fifo.v ----
`timescale 1ns/1ps
module gtw_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire core_clk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire nonempty;
  wire push;
  wire pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign nonempty = (wr_ptr != rd_ptr);
  assign in_ready = ~full;
  assign push = in_valid & ~full;
  // output stage refills whenever it is empty or being drained
  assign pop = nonempty & (~out_valid | out_ready);

  always @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr[AW-1:0]];
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // gtw_fifo

// ---- sim/gtw_port_sva.sv ----
`timescale 1ns/1ps
module gtw_port_sva (
  input wire core_clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [7:0] mem_rd_addr,
  input wire [7:0] mem_rd_data,
  input wire wr_valid,
  input wire wr_ready,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] bus_identity_low_bits
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence scl_high_run;
    scl_in [*3];
  endsequence
  sequence scl_idle_run;
    scl_in [*8];
  endsequence
  sequence word_held;
    wr_valid && $stable(wr_addr) && $stable(wr_data);
  endsequence
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  word_hold_a: assert property (wr_valid && !wr_ready |=> word_held)
    else $error("write word lost before acceptance");
  oe_change_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive changed near clock high");
  oe_still_high_a: assert property (scl_high_run |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  rise_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*7])
    else $error("low drive shorter than a bit");
  fall_hold_a: assert property ($fell(sda_oe) |-> !sda_oe [*7])
    else $error("release shorter than a bit");
  cfg_local_a: assert property (wr_valid |-> wr_addr != 8'h7d)
    else $error("identity location streamed");
  reset_init_a: assert property ($rose(arst_n) |-> bus_identity_low_bits == 4'h6 && !sda_oe)
    else $error("reset state wrong");
  idle_release_a: assert property (scl_idle_run |-> !sda_oe)
    else $error("data line pulled while bus clock idle");
endmodule // gtw_port_sva
bind gtw_port gtw_port_sva u_sva (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .mem_rd_addr(mem_rd_addr),
  .mem_rd_data(mem_rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
  .wr_data(wr_data), .bus_identity_low_bits(bus_identity_low_bits));

// ---- sim/gtw_master.sv ----
`timescale 1ns/1ps
module gtw_master (
  output logic scl,
  output logic sda_pull,
  input wire sda
);
  localparam Q = 80;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // also a repeated start when entered with the clock low
  task start;
  begin
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  end
  endtask
  task stop;
  begin
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #(2*Q);
  end
  endtask
  // data changes only mid-low so it is stable over the high phase
  task xbit(input logic v, output logic r);
  begin
    sda_pull = !v;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  end
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    logic r;
    integer i;
  begin
    for (i = 7; i >= 0; i--)
      xbit(b[i], r);
    xbit(1'b1, r);
    ack = !r;
  end
  endtask
  task rbyte(input logic last, output logic [7:0] b);
    logic r;
    integer i;
  begin
    for (i = 7; i >= 0; i--)
      xbit(1'b1, b[i]);
    xbit(last, r);
  end
  endtask
endmodule // gtw_master

// ---- sim/tb_gauge_two_wire_register_port.sv ----
`timescale 1ns/1ps
module tb_gauge_two_wire_register_port;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_ready = 1'b0;
  wire scl, pull, sda_out, sda_oe, wr_valid, sda;
  wire [7:0] mem_rd_addr, wr_addr, wr_data;
  wire [3:0] ident;
  integer bad_count = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer i;
  logic [15:0] expq[$];
  logic ack;
  logic [7:0] rb;
  logic [7:0] sa = 8'h6c;
  // open drain wire with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & !pull;
  gtw_master m (.scl(scl), .sda_pull(pull), .sda(sda));
  gtw_port DUT (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_addr ^ 8'h3c), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .bus_identity_low_bits(ident));
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task xfer(input logic [7:0] b, input logic e);
  begin
    m.wbyte(b, ack);
    chk("ack", {15'h0, e}, {15'h0, ack});
  end
  endtask
  task open_w(input logic [7:0] p);
  begin
    m.start;
    xfer(sa, 1'b1);
    xfer(p, 1'b1);
  end
  endtask
  task rd(input logic last, input logic [7:0] e);
  begin
    m.rbyte(last, rb);
    chk("read", {8'h0, e}, {8'h0, rb});
  end
  endtask
  // unexpected words compare against a value never streamed here
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      $display("ERROR cycle limit expected finish seen %0d cycles", cyc);
      print_verdict;
    end
    else if (wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      chk("word", expq.size() ? expq.pop_front() : 16'hffff, {wr_addr, wr_data});
    end
  end
  initial
  begin
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    wr_ready = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("ident", 16'h6, {12'h0, ident});
    m.start;
    xfer(8'h6c, 1'b1);
    m.stop;
    m.start;
    xfer(8'h6e, 1'b0);
    xfer(8'h00, 1'b0);
    m.stop;
    expq.push_back(16'h4e11);
    expq.push_back(16'h4f22);
    open_w(8'h4e);
    xfer(8'h11, 1'b1);
    xfer(8'h22, 1'b1);
    xfer(8'h33, 1'b1);
    m.stop;
    open_w(8'h7d);
    xfer(8'ha5, 1'b1);
    m.stop;
    chk("ident", 16'ha, {12'h0, ident});
    m.start;
    xfer(8'h6c, 1'b0);
    m.stop;
    sa = 8'h74;
    open_w(8'h7c);
    m.start;
    xfer(sa | 8'h01, 1'b1);
    rd(1'b0, 8'h7c ^ 8'h3c);
    rd(1'b1, 8'ha0);
    m.stop;
    open_w(8'hfe);
    m.start;
    xfer(sa | 8'h01, 1'b1);
    rd(1'b0, 8'hfe ^ 8'h3c);
    rd(1'b0, 8'hff ^ 8'h3c);
    rd(1'b0, 8'hff);
    rd(1'b1, 8'hff);
    m.stop;
    // a direct command write streams; bytes carried past it land nowhere
    expq.push_back(16'hfe5a);
    open_w(8'hfe);
    xfer(8'h5a, 1'b1);
    xfer(8'h77, 1'b1);
    xfer(8'h88, 1'b1);
    m.stop;
    // reset in mid-run brings back the default identity
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("ident", 16'h6, {12'h0, ident});
    m.start;
    xfer(sa, 1'b0);
    m.stop;
    sa = 8'h6c;
    // consumer stalls so the stream buffer fills and the last byte is refused
    wr_ready = 1'b0;
    open_w(8'h00);
    for (i = 0; i < 34; i++)
    begin
      if (i < 33)
        expq.push_back({i[7:0], i[7:0]});
      xfer(i[7:0], i < 33);
    end
    m.stop;
    wr_ready = 1'b1;
    for (i = 0; i < 200 && expq.size() > 0; i++)
      @(negedge core_clk);
    chk("drained", 16'h0, expq.size());
    print_verdict;
  end
endmodule // tb_gauge_two_wire_register_port
